// >>> common/mifb_pkg.sv
// Purpose: shared constants and types of the interrupt flag and enable bank
// Assumes: 32-bit APB, one word per register, 8 data bits used per register
// Notes:   offsets, masks, bit positions and codes live here; the bench tables repeat some as literals
package mifb_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_EDGE     = 8'h00;
  localparam logic [7:0] OFS_PRIM0    = 8'h04;
  localparam logic [7:0] OFS_PRIM1    = 8'h08;
  localparam logic [7:0] OFS_PRIM2    = 8'h0C;
  localparam logic [7:0] OFS_GRP0     = 8'h10;
  localparam logic [7:0] OFS_GRP3     = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // ==========================================================================
  // implemented bits; all others read zero and ignore writes
  localparam logic [7:0] IMPL_EDGE  = 8'h0F;
  localparam logic [7:0] IMPL_PRIM0 = 8'h7F;
  localparam logic [7:0] IMPL_PRIM1 = 8'hFF;
  localparam logic [7:0] IMPL_PRIM2 = 8'h33;
  localparam logic [7:0] IMPL_GRP0  = 8'h33;
  localparam logic [7:0] IMPL_GRP1  = 8'hFF;
  localparam logic [7:0] IMPL_GRP2  = 8'hBB;
  localparam logic [7:0] IMPL_GRP3  = 8'h33;
  localparam logic [7:0] IMPL_STAT  = 8'h07;
  localparam logic [7:0] RST_REG    = 8'h00;

  // ==========================================================================
  // bit positions
  localparam int unsigned EDGE0_LSB = 0;
  localparam int unsigned EDGE1_LSB = 2;
  localparam int unsigned P0_GLB    = 0;
  localparam int unsigned P0_EN0    = 1;
  localparam int unsigned P0_EN1    = 2;
  localparam int unsigned P0_GEN0   = 3;
  localparam int unsigned P0_F0     = 4;
  localparam int unsigned P0_F1     = 5;
  localparam int unsigned P0_GF0    = 6;
  localparam int unsigned P1_CONV_E = 0;
  localparam int unsigned P1_TK0_E  = 1;
  localparam int unsigned P1_TK1_E  = 2;
  localparam int unsigned P1_GEN1   = 3;
  localparam int unsigned P1_CONV_F = 4;
  localparam int unsigned P1_TK0_F  = 5;
  localparam int unsigned P1_TK1_F  = 6;
  localparam int unsigned P1_GF1    = 7;
  localparam int unsigned P2_GEN2   = 0;
  localparam int unsigned P2_GEN3   = 1;
  localparam int unsigned P2_GF2    = 4;
  localparam int unsigned P2_GF3    = 5;
  localparam int unsigned ST_TAKEN  = 0;
  localparam int unsigned ST_HELD   = 1;
  localparam int unsigned ST_PIN    = 2;

  // ==========================================================================
  // edge select codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // vectors in priority order, lowest code wins
  typedef enum logic [3:0] {
    VEC_EXT0  = 4'h0,
    VEC_EXT1  = 4'h1,
    VEC_GRP0  = 4'h2,
    VEC_CONV  = 4'h3,
    VEC_TICK0 = 4'h4,
    VEC_TICK1 = 4'h5,
    VEC_GRP1  = 4'h6,
    VEC_GRP2  = 4'h7,
    VEC_GRP3  = 4'h8
  } mifb_vec_e;

  // one-cycle event pulses from the on-chip peripherals
  typedef struct packed {
    logic tick1;
    logic tick0;
    logic conv_done;
    logic timer0_cmp_a;
    logic timer0_cmp_p;
    logic serial_port;
    logic sync_serial;
    logic nvdata;
    logic low_volt;
    logic twowire_timeout;
    logic timer1_cmp_a;
    logic timer1_cmp_p;
    logic timer2_cmp_a;
    logic timer2_cmp_p;
  } mifb_src_s;

endpackage

// >>> rtl/mifb_edge_det.sv
// Purpose: programmable edge catcher for one external interrupt pin
// Assumes: pin already synchronous to i_clk
// Notes:   first sample after reset only arms, so a high pin is no edge
`timescale 1ns/1ps
`default_nettype none
module mifb_edge_det
  import mifb_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // pin and edge select
  input  wire logic       i_pin,
  input  wire logic [1:0] i_sel,
  // one-cycle hit
  output logic            o_hit
);

  logic prev;
  logic armed;

  // ==========================================================================
  // previous pin level and arm bit
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev  <= 1'b0;
      armed <= 1'b0;
    end else begin
      prev  <= i_pin;
      armed <= 1'b1;
    end
  end

  // edge match by select code
  always_comb begin
    o_hit = armed && (((i_sel == EDGE_RISE || i_sel == EDGE_BOTH) && i_pin && !prev)
          || ((i_sel == EDGE_FALL || i_sel == EDGE_BOTH) && !i_pin && prev));
  end

  a_rise_hit: assert property (@(posedge i_clk) disable iff (i_srst)
    (armed && i_sel == EDGE_RISE && i_pin && !prev) |-> o_hit)
    else $error("rising edge not caught");
  a_off_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_sel == EDGE_OFF) |-> !o_hit)
    else $error("edge caught while disabled");

endmodule
`default_nettype wire

// >>> rtl/mifb_irq_bank.sv
// Purpose: interrupt flag and enable bank with APB registers and core vectoring
// Assumes: 40 MHz i_clk, synchronous pins, core acks with a one-cycle pulse
// Notes:   APB answers with pready in the access phase, no extra wait
//
// Contract
// - pin one edge field: 00 off, 01 rise, 10 fall, 11 both.
// - pin zero edge field in low bits, same coding.
// - global enable bit 0 of control zero gates every vector.
// - pin flags at bits 4,5 and enables at bits 1,2 of control zero.
// - group zero flag bit 6, enable bit 3 of control zero.
// - control one: group one 7/3, tick one 6/2, tick zero 5/1.
// - conversion done flag bit 4, enable bit 0 of control one.
// - control two: groups three and two flags 5,4 enables 1,0.
// - four group registers feed the four group requests.
// - group zero: timer0 compare A flag bit 5, enable bit 1.
// - group zero: timer0 compare P flag bit 4, enable bit 0.
// - groups one to three: flags upper nibble, enables lower nibble.
// - unimplemented bits ignore writes and read zero.
// - flags set regardless of enable; vector needs individual and global enable.
// - servicing a pin vector clears its flag and the global enable.
// - no acknowledge while the return stack is full.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mifb_irq_bank
  import mifb_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  input  wire logic [3:0]            i_pstrb,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  // request sources
  input  wire logic                  i_ext_pin_zero,
  input  wire logic                  i_ext_pin_one,
  input  wire mifb_pkg::mifb_src_s   i_src,
  // processor core
  input  wire logic                  i_stack_full,
  input  wire logic                  i_irq_ack,
  output logic                       o_irq_req,
  output mifb_pkg::mifb_vec_e        o_irq_vec,
  // software interrupt line
  output logic                       o_irq
);

  // ==========================================================================
  // storage
  logic [7:0] pin_edge_select;
  logic [7:0] primary_irq_ctrl_zero;
  logic [7:0] primary_irq_ctrl_one;
  logic [7:0] primary_irq_ctrl_two;
  logic [7:0] grp [4];
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;

  logic       hit0;
  logic       hit1;
  logic       apb_setup;
  logic       apb_fin;
  logic       wr_go;
  logic       rd_stat;
  logic       mapped;
  logic [7:0] rd_byte;
  logic       ack_go;
  logic [3:0] grp_cond;
  logic [8:0] pend;
  mifb_vec_e  next_vec;
  logic [7:0] grp_set [4];
  logic [7:0] grp_impl [4];
  logic [7:0] p0_clr;
  logic [7:0] p1_clr;
  logic [7:0] p2_clr;
  logic [7:0] next_stat;
  logic [7:0] stat_set;

  // ==========================================================================
  // flag update: clear then set, so a hardware event beats a clear
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic wr,
                                     input logic [7:0] wd, input logic [7:0] set,
                                     input logic [7:0] clr, input logic [7:0] impl);
    upd = (((wr ? wd : cur) & ~clr) | set) & impl;
  endfunction

  // write strobe for one register offset
  function automatic logic wr_at(input logic go, input logic [7:0] addr,
                                 input logic [7:0] ofs);
    wr_at = go && (addr == ofs);
  endfunction

  // ==========================================================================
  // external pin edge catchers
  mifb_edge_det u_edge0 (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_pin  (i_ext_pin_zero),
    .i_sel  (pin_edge_select[EDGE0_LSB +: 2]),
    .o_hit  (hit0)
  );

  mifb_edge_det u_edge1 (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_pin  (i_ext_pin_one),
    .i_sel  (pin_edge_select[EDGE1_LSB +: 2]),
    .o_hit  (hit1)
  );

  // ==========================================================================
  // apb phase decode
  assign apb_setup = i_psel && !i_penable;
  assign apb_fin   = i_psel && i_penable && o_pready;
  assign wr_go     = apb_fin && i_pwrite && i_pstrb[0];
  assign rd_stat   = apb_fin && !i_pwrite && (i_paddr == OFS_IRQ_STAT);
  assign mapped    = (i_paddr[1:0] == 2'h0) && (i_paddr <= OFS_IRQ_MASK);

  // read mux, unimplemented bits already zero in storage
  always_comb begin
    case (i_paddr)
      OFS_EDGE:     rd_byte = pin_edge_select;
      OFS_PRIM0:    rd_byte = primary_irq_ctrl_zero;
      OFS_PRIM1:    rd_byte = primary_irq_ctrl_one;
      OFS_PRIM2:    rd_byte = primary_irq_ctrl_two;
      OFS_IRQ_STAT: rd_byte = irq_stat;
      OFS_IRQ_MASK: rd_byte = irq_mask;
      default:      rd_byte = (mapped && i_paddr >= OFS_GRP0) ? grp[i_paddr[3:2]] : 8'h00;
    endcase
  end

  // answer registered in setup so outputs come from flops
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= apb_setup;
      if (apb_setup) begin
        o_prdata  <= {24'h00_0000, rd_byte};
        o_pslverr <= !mapped;
      end
    end
  end

  // ==========================================================================
  // edge selects
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_edge_select <= RST_REG;
    end else if (wr_at(wr_go, i_paddr, OFS_EDGE)) begin
      pin_edge_select <= i_pwdata[7:0] & IMPL_EDGE;
    end
  end

  // ==========================================================================
  // group registers; flags upper nibble, enables lower nibble
  always_comb begin
    grp_set[0]  = {2'h0, i_src.timer0_cmp_a, i_src.timer0_cmp_p, 4'h0};
    grp_set[1]  = {i_src.serial_port, i_src.sync_serial, i_src.nvdata,
                   i_src.low_volt, 4'h0};
    grp_set[2]  = {i_src.twowire_timeout, 1'b0, i_src.timer1_cmp_a,
                   i_src.timer1_cmp_p, 4'h0};
    grp_set[3]  = {2'h0, i_src.timer2_cmp_a, i_src.timer2_cmp_p, 4'h0};
    grp_impl[0] = IMPL_GRP0;
    grp_impl[1] = IMPL_GRP1;
    grp_impl[2] = IMPL_GRP2;
    grp_impl[3] = IMPL_GRP3;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < 4; i++) begin
        grp[i] <= RST_REG;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        grp[i] <= upd(grp[i], wr_go && mapped && (i_paddr[7:4] == OFS_GRP0[7:4])
                      && (i_paddr[3:2] == 2'(i)), i_pwdata[7:0], grp_set[i],
                      8'h00, grp_impl[i]);
      end
    end
  end

  // any enabled source flag raises its group flag
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      grp_cond[i] = |(grp[i][7:4] & grp[i][3:0]);
    end
  end

  // ==========================================================================
  // vector service clears the serviced flag and the global enable
  assign ack_go = i_irq_ack && o_irq_req;

  always_comb begin
    p0_clr = 8'h00;
    p1_clr = 8'h00;
    p2_clr = 8'h00;
    if (ack_go) begin
      p0_clr[P0_GLB] = 1'b1;
      case (o_irq_vec)
        VEC_EXT0:  p0_clr[P0_F0]     = 1'b1;
        VEC_EXT1:  p0_clr[P0_F1]     = 1'b1;
        VEC_GRP0:  p0_clr[P0_GF0]    = 1'b1;
        VEC_CONV:  p1_clr[P1_CONV_F] = 1'b1;
        VEC_TICK0: p1_clr[P1_TK0_F]  = 1'b1;
        VEC_TICK1: p1_clr[P1_TK1_F]  = 1'b1;
        VEC_GRP1:  p1_clr[P1_GF1]    = 1'b1;
        VEC_GRP2:  p2_clr[P2_GF2]    = 1'b1;
        VEC_GRP3:  p2_clr[P2_GF3]    = 1'b1;
        default:   p2_clr            = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // primary control registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      primary_irq_ctrl_zero <= RST_REG;
      primary_irq_ctrl_one  <= RST_REG;
      primary_irq_ctrl_two  <= RST_REG;
    end else begin
      primary_irq_ctrl_zero <= upd(primary_irq_ctrl_zero, wr_at(wr_go, i_paddr, OFS_PRIM0),
                                   i_pwdata[7:0], {1'b0, grp_cond[0], hit1, hit0, 4'h0},
                                   p0_clr, IMPL_PRIM0);
      primary_irq_ctrl_one  <= upd(primary_irq_ctrl_one, wr_at(wr_go, i_paddr, OFS_PRIM1),
                                   i_pwdata[7:0], {grp_cond[1], i_src.tick1, i_src.tick0,
                                   i_src.conv_done, 4'h0}, p1_clr, IMPL_PRIM1);
      primary_irq_ctrl_two  <= upd(primary_irq_ctrl_two, wr_at(wr_go, i_paddr, OFS_PRIM2),
                                   i_pwdata[7:0], {2'h0, grp_cond[3], grp_cond[2], 4'h0},
                                   p2_clr, IMPL_PRIM2);
    end
  end

  // ==========================================================================
  // pending requests, each needs flag and individual enable
  always_comb begin
    pend[0] = primary_irq_ctrl_zero[P0_F0]     && primary_irq_ctrl_zero[P0_EN0];
    pend[1] = primary_irq_ctrl_zero[P0_F1]     && primary_irq_ctrl_zero[P0_EN1];
    pend[2] = primary_irq_ctrl_zero[P0_GF0]    && primary_irq_ctrl_zero[P0_GEN0];
    pend[3] = primary_irq_ctrl_one[P1_CONV_F]  && primary_irq_ctrl_one[P1_CONV_E];
    pend[4] = primary_irq_ctrl_one[P1_TK0_F]   && primary_irq_ctrl_one[P1_TK0_E];
    pend[5] = primary_irq_ctrl_one[P1_TK1_F]   && primary_irq_ctrl_one[P1_TK1_E];
    pend[6] = primary_irq_ctrl_one[P1_GF1]     && primary_irq_ctrl_one[P1_GEN1];
    pend[7] = primary_irq_ctrl_two[P2_GF2]     && primary_irq_ctrl_two[P2_GEN2];
    pend[8] = primary_irq_ctrl_two[P2_GF3]     && primary_irq_ctrl_two[P2_GEN3];
  end

  // lowest pending index wins; scan from the top so it is written last
  always_comb begin
    next_vec = VEC_EXT0;
    for (int i = 8; i >= 0; i--) begin
      if (pend[i]) begin
        next_vec = mifb_vec_e'(4'(i));
      end
    end
  end

  // request to the core; held off by global enable and a full stack
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_irq_req <= 1'b0;
      o_irq_vec <= VEC_EXT0;
    end else begin
      o_irq_req <= primary_irq_ctrl_zero[P0_GLB] && (|pend)
                   && !i_stack_full && !ack_go;
      o_irq_vec <= next_vec;
    end
  end

  // ==========================================================================
  // software interrupt status: read clears only what the read returned
  always_comb begin
    stat_set           = 8'h00;
    stat_set[ST_TAKEN] = ack_go;
    stat_set[ST_HELD]  = primary_irq_ctrl_zero[P0_GLB] && (|pend) && i_stack_full;
    stat_set[ST_PIN]   = hit0 || hit1;
    next_stat          = upd(irq_stat, 1'b0, 8'h00, stat_set,
                             rd_stat ? o_prdata[7:0] : 8'h00, IMPL_STAT);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_stat <= RST_REG;
      irq_mask <= RST_REG;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      if (wr_at(wr_go, i_paddr, OFS_IRQ_MASK)) begin
        irq_mask <= i_pwdata[7:0] & IMPL_STAT;
      end
      o_irq    <= |(next_stat & irq_mask);
    end
  end

  // ==========================================================================
  // checks
  sequence s_ext0_taken;
    o_irq_req && (o_irq_vec == VEC_EXT0) && i_irq_ack;
  endsequence

  a_global_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    !primary_irq_ctrl_zero[P0_GLB] |=> !o_irq_req)
    else $error("request with global enable low");
  a_pin_flag_set: assert property (@(posedge i_clk) disable iff (i_srst)
    hit1 |=> primary_irq_ctrl_zero[P0_F1])
    else $error("pin one flag not set");
  a_group_zero_raise: assert property (@(posedge i_clk) disable iff (i_srst)
    (grp[0][5] && grp[0][1]) |=> primary_irq_ctrl_zero[P0_GF0])
    else $error("group zero flag not raised");
  a_tick_flag_set: assert property (@(posedge i_clk) disable iff (i_srst)
    i_src.tick1 |=> primary_irq_ctrl_one[P1_TK1_F])
    else $error("tick one flag not set");
  a_conv_flag_set: assert property (@(posedge i_clk) disable iff (i_srst)
    i_src.conv_done |=> primary_irq_ctrl_one[P1_CONV_F])
    else $error("conversion flag not set");
  a_group_three_raise: assert property (@(posedge i_clk) disable iff (i_srst)
    (grp[3][4] && grp[3][0]) |=> primary_irq_ctrl_two[P2_GF3])
    else $error("group three flag not raised");
  a_source_flag_set: assert property (@(posedge i_clk) disable iff (i_srst)
    i_src.timer0_cmp_p |=> grp[0][4])
    else $error("timer0 compare P flag not set");
  a_group_one_raise: assert property (@(posedge i_clk) disable iff (i_srst)
    (grp[1][7] && grp[1][3]) |=> primary_irq_ctrl_one[P1_GF1])
    else $error("group one flag not raised");
  a_unimpl_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_pready && $past(i_paddr) == OFS_PRIM2) |-> (o_prdata[31:0] & ~{24'h00_0000, IMPL_PRIM2}) == 32'h0)
    else $error("unimplemented bits read nonzero");
  a_req_needs_en: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_irq_req && o_irq_vec == VEC_EXT0) |-> $past(primary_irq_ctrl_zero[P0_EN0]))
    else $error("vector without individual enable");
  a_pin_service: assert property (@(posedge i_clk) disable iff (i_srst)
    s_ext0_taken |=> !primary_irq_ctrl_zero[P0_GLB] && !o_irq_req
                     && (!primary_irq_ctrl_zero[P0_F0] || $past(hit0)))
    else $error("pin service did not clear flag and global enable");
  a_stack_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    i_stack_full |=> !o_irq_req)
    else $error("request while stack full");

endmodule
`default_nettype wire

// >>> tb/mifb_core_model.sv
// Purpose: behavioural processor core that takes interrupt vectors
// Assumes: one-cycle acknowledge pulse, core delay set by i_wait
// Notes:   never acknowledges while its own return stack is full
`timescale 1ns/1ps
`default_nettype none
module mifb_core_model
  import mifb_pkg::*;
(
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  // request side
  input  wire logic                i_irq_req,
  input  wire mifb_pkg::mifb_vec_e i_irq_vec,
  input  wire logic                i_stack_full,
  input  wire logic [3:0]          i_wait,
  // acknowledge side
  output logic                     o_irq_ack,
  output mifb_pkg::mifb_vec_e      o_last_vec,
  output logic [7:0]               o_acks
);
  logic [3:0] waited;

  // ==========================================================================
  // ack after i_wait cycles; skip the cycle after an ack so one pulse per request
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_irq_ack  <= 1'b0;
      o_last_vec <= VEC_EXT0;
      o_acks     <= 8'h00;
      waited     <= 4'h0;
    end else begin
      o_irq_ack <= 1'b0;
      if (i_irq_req && !o_irq_ack && !i_stack_full) begin
        if (waited >= i_wait) begin
          o_irq_ack  <= 1'b1;
          o_last_vec <= i_irq_vec;
          o_acks     <= o_acks + 8'h01;
          waited     <= 4'h0;
        end else begin
          waited <= waited + 4'h1;
        end
      end else begin
        waited <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench for the interrupt flag and enable bank
// Assumes: zero-wait apb slave, core model acknowledges requests
// Notes:   expectations built from bit positions, not from the design
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mifb_pkg::*;
  // ==========================================================================
  // signals
  logic        i_clk, i_srst, psel, pen, pwr, pin0, pin1, full, err;
  logic        o_pready, o_pslverr, ack, o_irq_req, o_irq;
  logic [7:0]  paddr, acks;
  logic [31:0] pwdata, o_prdata, q;
  logic [13:0] src;
  logic [3:0]  wait_c;
  mifb_vec_e   vec, last;
  int          mismatches, checks;
  // group sources: register, flag bit, primary register, primary bit
  logic [7:0]  impl [8] = '{IMPL_EDGE, IMPL_PRIM0, IMPL_PRIM1, IMPL_PRIM2,
                            IMPL_GRP0, IMPL_GRP1, IMPL_GRP2, IMPL_GRP3};
  logic [7:0]  gofs [11] = '{8'h1C, 8'h1C, 8'h18, 8'h18, 8'h18, 8'h14, 8'h14, 8'h14, 8'h14, 8'h10, 8'h10};
  int          fb [11] = '{4, 5, 4, 5, 7, 4, 5, 6, 7, 4, 5};
  logic [7:0]  pofs [11] = '{8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h08, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04};
  int          pb [11] = '{5, 5, 4, 4, 4, 7, 7, 7, 7, 6, 6};

  mifb_irq_bank dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_ext_pin_zero(pin0), .i_ext_pin_one(pin1), .i_src(mifb_src_s'(src)),
    .i_stack_full(full), .i_irq_ack(ack), .o_irq_req(o_irq_req), .o_irq_vec(vec), .o_irq(o_irq));
  mifb_core_model core (.i_clk(i_clk), .i_srst(i_srst), .i_irq_req(o_irq_req), .i_irq_vec(vec),
    .i_stack_full(full), .i_wait(wait_c), .o_irq_ack(ack), .o_last_vec(last), .o_acks(acks));

  // 40 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ==========================================================================
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // one apb transfer; pready, data and error taken at the completing rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge i_clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED pready exp 1 got %b", o_pready);
      complete_run();
    end
    q   = o_prdata;
    err = o_pslverr;
    // release only after the edge that completed the access
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, q);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic pulse(input logic [13:0] m);
    @(posedge i_clk);
    src <= m;
    @(posedge i_clk);
    src <= '0;
    cyc(2);
  endtask

  task automatic pin(input int p, input logic v);
    @(posedge i_clk);
    if (p == 0) pin0 <= v;
    else pin1 <= v;
    cyc(3);
  endtask

  // bounded wait for the core to count n acknowledges
  task automatic wait_ack(input logic [7:0] n);
    int k;
    k = 0;
    while (acks !== n && k < 60) begin
      @(posedge i_clk);
      k++;
    end
    if (acks !== n) begin
      mismatches++;
      $display("CHECK FAILED ack count exp %0d got %0d", n, acks);
      complete_run();
    end
    cyc(2);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {i_srst, full} = 2'b11;
    {psel, pen, pwr, pin0, pin1} = '0;
    {paddr, pwdata, src, wait_c} = '0;
    mismatches = 0;
    checks = 0;
    cyc(5);
    i_srst <= 1'b0;
    // reset values, then implemented bits with vectoring held off
    for (int i = 0; i < 10; i++) begin
      rd(8'(4 * i), 8'h00, "reset value");
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'(4 * i), 8'hFF);
      rd(8'(4 * i), impl[i], "implemented bits");
      apb(1'b1, 8'(4 * i), 8'h00);
    end
    for (int i = 1; i < 4; i++) begin
      apb(1'b1, 8'(4 * i), 8'h00);
    end
    full <= 1'b0;
    rd(8'h28, 8'h00, "unmapped data");
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, OFS_IRQ_MASK, 8'h07);
    // every edge code on both pins, enables off
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, OFS_EDGE, 8'(c) << (2 * p));
        pin(p, 1'b1);
        rd(OFS_PRIM0, 8'(c[0]) << (4 + p), "rise flag");
        apb(1'b1, OFS_PRIM0, 8'h00);
        pin(p, 1'b0);
        rd(OFS_PRIM0, 8'(c[1]) << (4 + p), "fall flag");
        apb(1'b1, OFS_PRIM0, 8'h00);
      end
    end
    // conversion and tick flags
    for (int b = 11; b < 14; b++) begin
      pulse(14'(1) << b);
      rd(OFS_PRIM1, 8'(1) << (b - 7), "primary flag");
      apb(1'b1, OFS_PRIM1, 8'h00);
    end
    // every group source with its enable set
    for (int b = 0; b < 11; b++) begin
      apb(1'b1, gofs[b], 8'(1) << (fb[b] - 4));
      pulse(14'(1) << b);
      rd(gofs[b], (8'(1) << fb[b]) | (8'(1) << (fb[b] - 4)), "source flag");
      rd(pofs[b], 8'(1) << pb[b], "group flag");
      apb(1'b1, gofs[b], 8'h00);
      apb(1'b1, pofs[b], 8'h00);
    end
    // a source without its enable leaves the group quiet
    pulse(14'h0400);
    rd(OFS_GRP0, 8'h20, "disabled source");
    rd(OFS_PRIM0, 8'h00, "group stays off");
    apb(1'b1, OFS_GRP0, 8'h00);
    // pin vector: global off, then stack full, then serviced
    apb(1'b0, OFS_IRQ_STAT, 8'h00);
    apb(1'b1, OFS_EDGE, 8'h01);
    apb(1'b1, OFS_PRIM0, 8'h02);
    pin(0, 1'b1);
    rd(OFS_PRIM0, 8'h12, "flag without global");
    full <= 1'b1;
    apb(1'b1, OFS_PRIM0, 8'h13);
    cyc(4);
    @(negedge i_clk);
    chk("request with full stack", 32'h0, {31'h0, o_irq_req});
    @(posedge i_clk);
    full   <= 1'b0;
    wait_c <= 4'h3;
    wait_ack(8'h01);
    chk("pin vector", {28'h0, VEC_EXT0}, {28'h0, last});
    rd(OFS_PRIM0, 8'h02, "serviced pin");
    @(negedge i_clk);
    chk("irq line", 32'h1, {31'h0, o_irq});
    rd(OFS_IRQ_STAT, 8'h07, "status");
    @(negedge i_clk);
    chk("irq after read", 32'h0, {31'h0, o_irq});
    // two pending vectors, lowest code first, line masked
    apb(1'b1, OFS_IRQ_MASK, 8'h00);
    apb(1'b1, OFS_PRIM1, 8'h03);
    pulse(14'h1800);
    apb(1'b1, OFS_PRIM0, 8'h01);
    wait_ack(8'h02);
    chk("first vector", {28'h0, VEC_CONV}, {28'h0, last});
    rd(OFS_PRIM1, 8'h23, "tick still pending");
    apb(1'b1, OFS_PRIM0, 8'h01);
    wait_ack(8'h03);
    chk("second vector", {28'h0, VEC_TICK0}, {28'h0, last});
    @(negedge i_clk);
    chk("masked irq", 32'h0, {31'h0, o_irq});
    rd(OFS_IRQ_STAT, 8'h01, "masked status");
    complete_run();
  end
endmodule
`default_nettype wire
